// ---- ddrsr_cfg.svh ----
// Constants of the burst-of-two double-rate static RAM port
`ifndef DDRSR_CFG_SVH
`define DDRSR_CFG_SVH

// Organization: 18-bit words, two byte lanes of 9 bits
`define DDRSR_DATA_W 18
`define DDRSR_LANE_W 9
`define DDRSR_LANES 2
// Burst address selects one pair of words
`define DDRSR_ADDR_W 19
`define DDRSR_BURST_LEN 2

// Positions of the four sampled clock pins in the clock vector
`define DDRSR_CLK_K 0
`define DDRSR_CLK_KN 1
`define DDRSR_CLK_C 2
`define DDRSR_CLK_CN 3
`define DDRSR_CLK_W 4

// Reset values
`define DDRSR_CLK_RST 4'hF
`define DDRSR_DATA_RST 18'h00000
`define DDRSR_ADDR_RST 19'h00000
`define DDRSR_LANES_RST 2'h3
`define DDRSR_ECHO_RST 2'h2

`endif

// ---- ddrsr_pkg.sv ----
// Types of the burst-of-two double-rate static RAM port
`include "ddrsr_cfg.svh"

package ddrsr_pkg;

    // One sampled snapshot of every input pin
    typedef struct packed {
        logic [`DDRSR_CLK_W-1:0] clk;
        logic ld_n;
        logic rw;
        logic [`DDRSR_ADDR_W-1:0] addr;
        logic [`DDRSR_LANES-1:0] lanes_n;
        logic [`DDRSR_DATA_W-1:0] wdata;
    } ddrsr_pins_t;

    // Whole state of the port except the storage array
    typedef struct packed {
        ddrsr_pins_t sync1;
        ddrsr_pins_t sync2;
        ddrsr_pins_t sync3;
        logic [`DDRSR_CLK_W-1:0] clk_lvl;
        logic wr_first_vld;
        logic [`DDRSR_ADDR_W-1:0] wr_first_addr;
        logic wr_second_vld;
        logic [`DDRSR_ADDR_W-1:0] wr_second_addr;
        logic rd_load_vld;
        logic [`DDRSR_ADDR_W-1:0] rd_load_addr;
        logic rd_arm_vld;
        logic [`DDRSR_ADDR_W-1:0] rd_arm_addr;
        logic rd_second_vld;
        logic [`DDRSR_ADDR_W-1:0] rd_second_addr;
        logic [`DDRSR_DATA_W-1:0] rdata;
        logic rdata_en;
        logic [1:0] echo;
    } ddrsr_state_t;

endpackage

// ---- ddrsr_port.sv ----
// Device side of a burst-of-two double-rate static RAM with separate buses
`timescale 1ns/1ps
`default_nettype none
`include "ddrsr_cfg.svh"

// Contract
// - Address captured on primary input clock rise
// - Every transaction moves exactly two words
// - Address ignored while load strobe inactive
// - Data buses are 8, 18 or 36 bits; this port is fixed at 18 bits
// - Write data taken on both input clock rises
// - Address and control sampled on primary rise only
// - Read/write select high reads, low writes
// - Lane written only while its enable low
// - Lane enables sampled separately per burst word
// - First read word on complementary output rise
// - Second read word on primary output rise
// - Output clocks held high select input clocks
// - Read bus driven only for read commands
// - Write words at K and /K of t+1
// - Read words at /C(t+1) and C(t+2)
// - Echo clocks free-running, aligned with read data
module ddrsr_port (
    input wire logic clock_in,                                // Oversampling core clock
    input wire logic sys_rst_in,                              // Synchronous reset, high
    input wire logic ce_in,                                   // Clock enable, freezes state
    input wire logic k_in,                                    // Primary input clock pin
    input wire logic k_n_in,                                  // Complementary input clock pin
    input wire logic c_in,                                    // Primary output clock pin
    input wire logic c_n_in,                                  // Complementary output clock pin
    input wire logic load_strobe_n_in,                        // Load strobe, low starts burst
    input wire logic read_write_in,                           // High read, low write
    input wire logic [`DDRSR_ADDR_W-1:0] addr_in,             // Burst address
    input wire logic [`DDRSR_LANES-1:0] byte_lane_write_en_n_in, // Lane enables, low writes
    input wire logic [`DDRSR_DATA_W-1:0] write_data_in,       // Write data bus
    output logic [`DDRSR_DATA_W-1:0] read_data_out,           // Read data bus
    output logic read_data_en_out,                            // High while read bus driven
    output logic [1:0] echo_clock_pair_out                    // Echo clocks, [1] true, [0] inverted
);

    ddrsr_pkg::ddrsr_state_t state;
    ddrsr_pkg::ddrsr_state_t next_state;

    // Storage, one entry per burst word
    logic [`DDRSR_DATA_W-1:0] mem [0:(2**(`DDRSR_ADDR_W+1))-1];

    ddrsr_pkg::ddrsr_pins_t pins;
    logic [`DDRSR_CLK_W-1:0] rise;
    logic [`DDRSR_CLK_W-1:0] next_lvl;
    logic use_k_ref;
    logic ref_first_rise;
    logic ref_second_rise;
    logic mem_we;
    logic [`DDRSR_ADDR_W:0] mem_waddr;
    logic [`DDRSR_DATA_W-1:0] mem_wdata;
    logic [`DDRSR_LANES-1:0] mem_lanes_n;

    // Word index of one beat within a burst
    function automatic logic [`DDRSR_ADDR_W:0] word_index(
        input logic [`DDRSR_ADDR_W-1:0] addr,
        input logic beat
    );
        word_index = {addr, beat};
    endfunction

    // Keeps old lanes whose enable is high
    function automatic logic [`DDRSR_DATA_W-1:0] merge_lanes(
        input logic [`DDRSR_DATA_W-1:0] old_word,
        input logic [`DDRSR_DATA_W-1:0] new_word,
        input logic [`DDRSR_LANES-1:0] lanes_n
    );
        logic [`DDRSR_DATA_W-1:0] result;
        result = old_word;
        for (int i = 0; i < `DDRSR_LANES; i++) begin
            if (!lanes_n[i]) begin
                result[i*`DDRSR_LANE_W +: `DDRSR_LANE_W] =
                    new_word[i*`DDRSR_LANE_W +: `DDRSR_LANE_W];
            end
        end
        merge_lanes = result;
    endfunction

    assign pins.clk = {c_n_in, c_in, k_n_in, k_in};
    assign pins.ld_n = load_strobe_n_in;
    assign pins.rw = read_write_in;
    assign pins.addr = addr_in;
    assign pins.lanes_n = byte_lane_write_en_n_in;
    assign pins.wdata = write_data_in;

    // Clock pin edges count once second and third stage agree
    always_comb begin
        for (int i = 0; i < `DDRSR_CLK_W; i++) begin
            if (state.sync2.clk[i] == state.sync3.clk[i]) begin
                next_lvl[i] = state.sync3.clk[i];
            end else begin
                next_lvl[i] = state.clk_lvl[i];
            end
            rise[i] = next_lvl[i] && !state.clk_lvl[i];
        end
    end

    // Output clocks both high hand timing over to the input pair
    always_comb begin
        use_k_ref = state.clk_lvl[`DDRSR_CLK_C] && state.clk_lvl[`DDRSR_CLK_CN] &&
                    next_lvl[`DDRSR_CLK_C] && next_lvl[`DDRSR_CLK_CN];
        if (use_k_ref) begin
            ref_first_rise = rise[`DDRSR_CLK_KN];
            ref_second_rise = rise[`DDRSR_CLK_K];
        end else begin
            ref_first_rise = rise[`DDRSR_CLK_CN];
            ref_second_rise = rise[`DDRSR_CLK_C];
        end
    end

    // Write port of the storage, data aligned with the sampled clocks
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_wdata = state.sync3.wdata;
        mem_lanes_n = state.sync3.lanes_n;
        if (rise[`DDRSR_CLK_K] && state.wr_first_vld) begin
            mem_we = 1'b1;
            mem_waddr = word_index(state.wr_first_addr, 1'b0);
        end else if (rise[`DDRSR_CLK_KN] && state.wr_second_vld) begin
            mem_we = 1'b1;
            mem_waddr = word_index(state.wr_second_addr, 1'b1);
        end
    end

    always_comb begin
        next_state = state;
        next_state.sync1 = pins;
        next_state.sync2 = state.sync1;
        next_state.sync3 = state.sync2;
        next_state.clk_lvl = next_lvl;

        // Second write beat follows the first on the next /K rise
        if (rise[`DDRSR_CLK_KN]) begin
            next_state.wr_second_vld = 1'b0;
        end

        if (rise[`DDRSR_CLK_K]) begin
            // Beats of the previous load move one cycle on
            next_state.wr_second_vld = state.wr_first_vld;
            next_state.wr_second_addr = state.wr_first_addr;
            next_state.rd_arm_vld = state.rd_load_vld;
            next_state.rd_arm_addr = state.rd_load_addr;
            next_state.wr_first_vld = 1'b0;
            next_state.rd_load_vld = 1'b0;
            // Control sampled only here, every cycle
            if (!state.sync3.ld_n) begin
                if (state.sync3.rw) begin
                    next_state.rd_load_vld = 1'b1;
                    next_state.rd_load_addr = state.sync3.addr;
                end else begin
                    next_state.wr_first_vld = 1'b1;
                    next_state.wr_first_addr = state.sync3.addr;
                end
            end
        end

        // First read word, bus released when no read is armed
        if (ref_first_rise) begin
            if (state.rd_arm_vld) begin
                next_state.rdata = mem[word_index(state.rd_arm_addr, 1'b0)];
                next_state.rdata_en = 1'b1;
                next_state.rd_second_vld = 1'b1;
                next_state.rd_second_addr = state.rd_arm_addr;
            end else begin
                next_state.rdata_en = 1'b0;
                next_state.rd_second_vld = 1'b0;
            end
            // Arm consumed once its first word is out
            if (!rise[`DDRSR_CLK_K]) begin
                next_state.rd_arm_vld = 1'b0;
            end
        end

        // Second read word closes the burst
        if (ref_second_rise) begin
            if (state.rd_second_vld) begin
                next_state.rdata = mem[word_index(state.rd_second_addr, 1'b1)];
                next_state.rdata_en = 1'b1;
                next_state.rd_second_vld = 1'b0;
            end else begin
                next_state.rdata_en = 1'b0;
            end
        end

        // Echo steps on the same rises as the data, never gated by reads;
        // stepping only on rises avoids a false edge while levels settle after reset
        if (ref_first_rise) begin
            next_state.echo = ~`DDRSR_ECHO_RST;
        end
        if (ref_second_rise) begin
            next_state.echo = `DDRSR_ECHO_RST;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state.sync1 <= '{clk: `DDRSR_CLK_RST, ld_n: 1'b1, rw: 1'b0,
                             addr: `DDRSR_ADDR_RST, lanes_n: `DDRSR_LANES_RST,
                             wdata: `DDRSR_DATA_RST};
            state.sync2 <= '{clk: `DDRSR_CLK_RST, ld_n: 1'b1, rw: 1'b0,
                             addr: `DDRSR_ADDR_RST, lanes_n: `DDRSR_LANES_RST,
                             wdata: `DDRSR_DATA_RST};
            state.sync3 <= '{clk: `DDRSR_CLK_RST, ld_n: 1'b1, rw: 1'b0,
                             addr: `DDRSR_ADDR_RST, lanes_n: `DDRSR_LANES_RST,
                             wdata: `DDRSR_DATA_RST};
            state.clk_lvl <= `DDRSR_CLK_RST;
            state.wr_first_vld <= 1'b0;
            state.wr_first_addr <= `DDRSR_ADDR_RST;
            state.wr_second_vld <= 1'b0;
            state.wr_second_addr <= `DDRSR_ADDR_RST;
            state.rd_load_vld <= 1'b0;
            state.rd_load_addr <= `DDRSR_ADDR_RST;
            state.rd_arm_vld <= 1'b0;
            state.rd_arm_addr <= `DDRSR_ADDR_RST;
            state.rd_second_vld <= 1'b0;
            state.rd_second_addr <= `DDRSR_ADDR_RST;
            state.rdata <= `DDRSR_DATA_RST;
            state.rdata_en <= 1'b0;
            state.echo <= `DDRSR_ECHO_RST;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    // Storage is not reset; contents are undefined after power-up
    always_ff @(posedge clock_in) begin
        if (ce_in && !sys_rst_in && mem_we) begin
            mem[mem_waddr] <= merge_lanes(mem[mem_waddr], mem_wdata, mem_lanes_n);
        end
    end

    // Fixed at the 18-bit organization
    assign read_data_out = state.rdata;
    assign read_data_en_out = state.rdata_en;
    assign echo_clock_pair_out = state.echo;

endmodule
`default_nettype wire

// ---- ddrsr_port_sva.sv ----
// Checker of the burst-of-two double-rate static RAM port
`timescale 1ns/1ps
`default_nettype none
`include "ddrsr_cfg.svh"
module ddrsr_port_chk (
    input wire logic clock_in, // Core clock
    input wire logic sys_rst_in, // Reset
    input wire logic k_in, // Input clock
    input wire logic k_n_in, // Input clock, inverted
    input wire logic c_in, // Output clock
    input wire logic c_n_in, // Output clock, inverted
    input wire logic load_strobe_n_in, // Load strobe
    input wire logic read_write_in, // Direction
    input wire logic [`DDRSR_DATA_W-1:0] read_data_out, // Read data
    input wire logic read_data_en_out, // Read bus driven
    input wire logic [1:0] echo_clock_pair_out // Echo clocks
);
    // Read latency window for pin half periods of 8 core cycles
    localparam int RD_MIN = 24;
    localparam int RD_MAX = 36;
    logic [1:0] ref_q;
    logic [7:0] hist;
    logic [1:0] rd_hist;
    logic [7:0] echo_age;
    logic k_q;
    wire [1:0] ref_now = (c_in & c_n_in) ? {k_in, k_n_in} : {c_in, c_n_in};
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ref_q <= 2'h3;
            hist <= 8'h00;
            rd_hist <= 2'h0;
            echo_age <= 8'h00;
            k_q <= 1'b1;
        end else begin
            ref_q <= ref_now;
            hist <= {hist[6:0], |(ref_now & ~ref_q)};
            k_q <= k_in;
            if (k_in && !k_q) begin
                rd_hist <= {rd_hist[0], !load_strobe_n_in && read_write_in};
            end
            echo_age <= $changed(echo_clock_pair_out[1]) ? 8'h00 : echo_age + 8'h01;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    AST_RESET_OUT: assert property (disable iff (1'b0) sys_rst_in |=>
        !read_data_en_out && echo_clock_pair_out == 2'h2) else $error("reset outputs wrong");
    AST_DATA_ON_REF: assert property ($changed(read_data_out) |-> |hist[5:2])
        else $error("read data moved off its reference");
    AST_EN_ON_REF: assert property ($changed(read_data_en_out) |-> |hist[5:2])
        else $error("read enable moved off its reference");
    AST_EN_ONLY_READ: assert property ($rose(read_data_en_out) |-> rd_hist[1])
        else $error("read bus driven without a read");
    AST_READ_LAT: assert property ($rose(k_in) && !load_strobe_n_in && read_write_in
        |-> ##[RD_MIN:RD_MAX] read_data_en_out) else $error("read data late");
    AST_ECHO_ALIGN: assert property ($rose(echo_clock_pair_out[1])
        || $rose(echo_clock_pair_out[0]) |-> |hist[5:2]) else $error("echo off reference");
    AST_ECHO_PAIR: assert property (echo_clock_pair_out[1] != echo_clock_pair_out[0])
        else $error("echo clocks not complementary");
    AST_ECHO_RUNS: assert property (echo_age < 8'h18) else $error("echo clock stopped");
    C_TIED_READ: cover property ($rose(read_data_en_out) && c_in && c_n_in);
    C_WRITE: cover property ($rose(k_in) && !load_strobe_n_in && !read_write_in);
    C_B2B_READ: cover property ($rose(k_in) && !load_strobe_n_in && read_write_in && rd_hist[0]);
endmodule
bind ddrsr_port ddrsr_port_chk u_ddrsr_port_chk (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .k_in(k_in), .k_n_in(k_n_in), .c_in(c_in), .c_n_in(c_n_in),
    .load_strobe_n_in(load_strobe_n_in), .read_write_in(read_write_in),
    .read_data_out(read_data_out), .read_data_en_out(read_data_en_out),
    .echo_clock_pair_out(echo_clock_pair_out));
`default_nettype wire

// ---- ddrsr_ctrl_model.sv ----
// Memory controller model driving the port's pins
`timescale 1ns/1ps
`default_nettype none
module ddrsr_ctrl_model (
    input wire logic clock_in, // Core clock
    input wire logic sys_rst_in, // Reset
    input wire logic tie_c_in, // Hold output clocks high
    input wire logic [60:0] cmd_in, // {ld_n, rw, addr, lanes, data}
    output logic take_out, // Command taken
    output logic [3:0] clk_out, // {c_n, c, k_n, k}
    output logic ld_n_out, // Load strobe
    output logic rw_out, // Direction
    output logic [18:0] addr_out, // Address
    output logic [1:0] lanes_n_out, // Lane enables
    output logic [17:0] wdata_out // Write data
);
    logic [3:0] ph;
    logic [39:0] pend;
    logic [19:0] hold;
    wire [3:0] phc = ph - 4'h2;
    // Output clocks lag by two core cycles so a wrong reference shows
    assign clk_out = {tie_c_in | phc[3], tie_c_in | !phc[3], ph[3], !ph[3]};
    always @(negedge clock_in) begin
        take_out <= 1'b0;
        ph <= sys_rst_in ? 4'h0 : ph + 4'h1;
        if (sys_rst_in) begin
            ld_n_out <= 1'b1;
        end else if (ph == 4'hB) begin
            {ld_n_out, rw_out, addr_out} <= cmd_in[60:40];
            {lanes_n_out, wdata_out} <= {pend[37:36], pend[17:0]};
            hold <= {pend[39:38], pend[35:18]};
            pend <= cmd_in[39:0];
            take_out <= 1'b1;
        end else if (ph == 4'h3) begin
            {lanes_n_out, wdata_out} <= hold;
            // Garbage control at the complementary rise must be ignored
            {ld_n_out, rw_out, addr_out} <= ~{ld_n_out, rw_out, addr_out};
        end
    end
endmodule
`default_nettype wire

// ---- ddrsr_port_tb.sv ----
// Self-checking bench of the double-rate static RAM port
`timescale 1ns/1ps
`default_nettype none
`include "ddrsr_cfg.svh"
module ddrsr_port_tb;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic tie_c = 1'b0;
    logic [60:0] cmd = {1'b1, 60'h0};
    logic take, ld_n, rw, rd_en;
    logic [3:0] pins;
    logic [18:0] addr;
    logic [1:0] lanes_n, echo, last;
    logic [17:0] wdata, rdata;
    logic [17:0] mem [0:31];
    logic [1:0] rose_q = 2'h0;
    logic prev_rd = 1'b0;
    logic [17:0] exp_q [$];
    logic [1:0] ref_q = 2'h0;
    logic [3:0] cnt = 4'h0;
    logic [2:0] last_idx = 3'h0;
    int errors = 0, n_checks = 0, seed = 76, cycles = 0;
    wire [1:0] rnow = tie_c ? pins[1:0] : pins[3:2];
    initial forever #5 clock_in = ~clock_in;
    ddrsr_port u_ddrsr_port (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
        .k_in(pins[0]), .k_n_in(pins[1]), .c_in(pins[2]), .c_n_in(pins[3]),
        .load_strobe_n_in(ld_n), .read_write_in(rw), .addr_in(addr),
        .byte_lane_write_en_n_in(lanes_n), .write_data_in(wdata), .read_data_out(rdata),
        .read_data_en_out(rd_en), .echo_clock_pair_out(echo));
    ddrsr_ctrl_model u_ddrsr_ctrl_model (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .tie_c_in(tie_c), .cmd_in(cmd), .take_out(take), .clk_out(pins), .ld_n_out(ld_n),
        .rw_out(rw), .addr_out(addr), .lanes_n_out(lanes_n), .wdata_out(wdata));
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    function automatic logic [35:0] rnd();
        rnd = 36'({$random(seed), $random(seed)});
    endfunction
    // Op 0 idle with random select and address, 1 write, 2 read
    task automatic issue(input logic [1:0] op, input logic [2:0] idx, input logic [3:0] m);
        logic [19:0] a;
        logic [35:0] d;
        logic [4:0] w;
        d = rnd();
        a = {tie_c ? 16'hFFFF : 16'h0000, idx, 1'b0};
        cmd = {op == 2'h0, op[1] | (op == 2'h0 & d[0]), op == 2'h0 ? d[18:0] : a[19:1], m, d};
        do @(negedge clock_in); while (take !== 1'b1);
        for (int b = 0; b < 2; b++) begin
            // Low bits of the word index tell the two modes' regions apart
            w = 5'(a + 20'(b));
            if (op == 2'h2) exp_q.push_back(mem[w]);
            for (int l = 0; l < 2; l++) begin
                if (op == 2'h1 && !m[2 * b + l]) mem[w][9 * l +: 9] = d[18 * b + 9 * l +: 9];
            end
        end
    endtask
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        ref_q <= rnow;
        if (|(rnow & ~ref_q)) rose_q <= rnow & ~ref_q;
        cnt <= (|(rnow & ~ref_q)) ? 4'h1 : (cnt == 4'h0 ? 4'h0 : cnt + 4'h1);
        if (cnt == 4'h6 && rd_en === 1'b1) begin
            check(18'(echo), 18'({rose_q[0], rose_q[1]}));
            if (exp_q.size() == 0) check(18'(rd_en), 18'h0);
            else check(rdata, exp_q.pop_front());
        end
        if (cycles == 10000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        for (int mode = 0; mode < 2; mode++) begin
            sys_rst_in <= 1'b1;
            tie_c = mode[0];
            repeat (5) @(negedge clock_in);
            check(18'({rd_en, echo}), 18'h2);
            sys_rst_in <= 1'b0;
            for (int i = 0; i < 8; i++) issue(2'h1, 3'(i), 4'h0);
            for (int i = 0; i < 16; i++) begin
                issue(2'h1, 3'(i), 4'($random(seed)));
                issue(2'h0, 3'h0, 4'($random(seed)));
            end
            for (int i = 0; i < 8; i++) issue(2'h2, 3'(i), 4'hF);
            $display("test fill and read mode %0d done", mode);
            for (int i = 0; i < 48; i++) begin
                last = 2'($unsigned($random(seed)) % 3);
                // Write to the pair after the one just read, right behind that read, races the launch
                if (last == 2'h1 && prev_rd && last_idx == 3'(i)) last = 2'h0;
                issue(last, 3'(i), 4'($random(seed)));
                prev_rd = (last == 2'h2);
                last_idx = 3'(i + 1);
            end
            repeat (3) issue(2'h0, 3'h0, 4'hF);
            repeat (40) @(negedge clock_in);
            check(18'(exp_q.size()), 18'h0);
            $display("test mixed mode %0d done", mode);
        end
        final_report();
    end
endmodule
`default_nettype wire
